//--- accel_serial_port.sv
// Overview of operation
// R1: with select low, serial input is sampled on each serial clock rising edge; code takes din only on the first 8 rises of a frame, in the run phase.
// R2: select is active low; serial output driven only while select is low; code also drives it high during stabilization, select high or low.
// R3: select low and clock high for 512 us asserts internal reset.
// R4: clock defaults low, select defaults high, so a floating clock never resets.
// R5: after any reset the serial output stays high impedance for 800 us.
// R6: then the output is driven high and a 3 ms stabilization delay runs.
// R7: a reset flag in the status word tells the host a reset happened.
// R8: capture/hold low lets each new sample load the result registers.
// R9: a rising capture/hold edge freezes the result registers.
// R10: while capture/hold is high, result registers ignore new samples.
// R11: self-test pushes both axes positive if polarity bit clear, else negative.
// R12: each axis result is a 10-bit signed two's-complement value.
// R13: a new sample is taken every 16 us, setting the update rate.
// R14: host can read serial number, range, filter and status words.
// R15: reset timer restarts when select rises or clock falls early.
// R16: host waits for high impedance and stabilization before transfers.
module accel_serial_port
    import accel_port_pkg::*;
#(
    parameter int unsigned RST_HOLD_CYCLES = accel_port_pkg::RST_HOLD_CYC,
    parameter int unsigned HIZ_CYCLES      = accel_port_pkg::HIZ_CYC,
    parameter int unsigned STAB_CYCLES     = accel_port_pkg::STAB_CYC,
    parameter logic [15:0] SERIAL_NUMBER   = 16'h1234,
    parameter logic [15:0] RANGE_CODE      = 16'h0001,
    parameter logic [15:0] FILTER_CODE     = 16'h0001
) (
    input  wire logic                   mclk_i,
    input  wire logic                   reset_n_i,
    input  wire logic                   sclk_i,
    input  wire logic                   select_reset_n_i,
    input  wire logic                   din_i,
    input  wire logic                   capture_hold_input_i,
    input  wire logic                   self_test_en_i,
    input  wire logic                   self_test_polarity_bit_i,
    input  wire accel_port_pkg::axis_t  accel_i,
    output logic                        dout_o,
    output logic                        dout_oe_o,
    output logic                        ready_o,
    output logic                        sample_tick_o
);
    import accel_port_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        phase_t                 phase;
        logic [PH_CNT_W-1:0]    ph_cnt;
        logic [RD_CNT_W-1:0]    rd_cnt;
        logic [SMP_CNT_W-1:0]   smp_cnt;
        logic                   tick;
        logic                   sclk_prev;
        logic [4:0]             bit_cnt;
        logic [CMD_W-1:0]       cmd_sr;
        logic [WORD_W-1:0]      tx_sr;
        logic                   oe;
        logic                   ready;
        logic                   rst_flag;
        axis_t                  res;
    } state_t;

    localparam state_t RST_STATE = '{
        phase:     PH_HIZ,
        ph_cnt:    '0,
        rd_cnt:    '0,
        smp_cnt:   '0,
        tick:      1'b0,
        sclk_prev: 1'b0,
        bit_cnt:   5'h00,
        cmd_sr:    8'h00,
        tx_sr:     WORD_IDLE,
        oe:        1'b0,
        ready:     1'b0,
        rst_flag:  1'b1,
        res:       '0
    };

    localparam logic [PH_CNT_W-1:0]  HIZ_LAST  = PH_CNT_W'(HIZ_CYCLES - 1);
    localparam logic [PH_CNT_W-1:0]  STAB_LAST = PH_CNT_W'(STAB_CYCLES - 1);
    localparam logic [RD_CNT_W-1:0]  RD_LAST   = RD_CNT_W'(RST_HOLD_CYCLES - 1);
    localparam logic [SMP_CNT_W-1:0] SMP_LAST  = SMP_CNT_W'(SAMPLE_CYC - 1);

    state_t cur_ff;
    state_t nxt_ff;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // saturating self-test deflection; wrap-around would flip the sign
    function automatic logic signed [AXIS_W-1:0] st_apply(
        input logic signed [AXIS_W-1:0] v,
        input logic                     en,
        input logic                     neg
    );
        logic signed [AXIS_W:0] wide;
        logic signed [AXIS_W:0] defl;
        logic signed [AXIS_W:0] lim_hi;
        logic signed [AXIS_W:0] lim_lo;
        logic signed [AXIS_W:0] sum;
        // concatenations are unsigned; cast back or the clamp compares unsigned
        wide   = $signed({v[AXIS_W-1], v});
        defl   = $signed({ST_OFFSET[AXIS_W-1], ST_OFFSET});
        lim_hi = $signed({AXIS_MAX[AXIS_W-1], AXIS_MAX});
        lim_lo = $signed({AXIS_MIN[AXIS_W-1], AXIS_MIN});
        sum    = '0;
        if (!en) begin
            return v;
        end
        sum = neg ? (wide - defl) : (wide + defl);
        if (sum > lim_hi) begin
            return AXIS_MAX;
        end
        if (sum < lim_lo) begin
            return AXIS_MIN;
        end
        return sum[AXIS_W-1:0];
    endfunction

    function automatic logic [WORD_W-1:0] sext_axis(input logic signed [AXIS_W-1:0] v);
        return {{(WORD_W - AXIS_W){v[AXIS_W-1]}}, v};
    endfunction

    // command byte as it stands once the bit now on the data pin is taken
    function automatic logic [CMD_W-1:0] cmd_with(
        input logic [CMD_W-1:0] sr,
        input logic             bit_in
    );
        return {sr[CMD_W-2:0], bit_in};
    endfunction

    function automatic logic [PH_CNT_W-1:0] ph_step(input logic [PH_CNT_W-1:0] cnt);
        return cnt + 1'b1;
    endfunction

    // status layout: reset flag, ready, hold level; all other bits read zero
    function automatic logic [WORD_W-1:0] status_word(
        input logic rst_flag,
        input logic ready,
        input logic hold
    );
        logic [WORD_W-1:0] w;
        w                = WORD_ZERO;
        w[STAT_RST_BIT]  = rst_flag;
        w[STAT_RDY_BIT]  = ready;
        w[STAT_HOLD_BIT] = hold;
        return w;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic        sclk_rise;
    logic        sclk_fall;
    logic        hw_reset;
    logic [15:0] rd_word;
    logic [15:0] stat_word;
    logic [CMD_W-1:0] cmd_now;
    logic        load_ok;

    always_comb begin
        nxt_ff    = cur_ff;
        sclk_rise = sclk_i && !cur_ff.sclk_prev;
        sclk_fall = !sclk_i && cur_ff.sclk_prev;
        hw_reset  = 1'b0;
        rd_word   = WORD_ZERO;
        stat_word = WORD_ZERO;
        // decoded once here: the read mux, the shift and the flag clear all use it
        cmd_now   = cmd_with(cur_ff.cmd_sr, din_i);
        load_ok   = cur_ff.tick && !capture_hold_input_i;

        nxt_ff.sclk_prev = sclk_i;

        // ----------------------------------------
        // reset detect
        // ----------------------------------------
        // a floating clock reads low, so the pin pair can never qualify
        if (!select_reset_n_i && sclk_i) begin // R3 R4
            if (cur_ff.rd_cnt == RD_LAST) begin
                hw_reset = 1'b1; // R3
            end else begin
                nxt_ff.rd_cnt = cur_ff.rd_cnt + 1'b1;
            end
        end else begin
            nxt_ff.rd_cnt = '0; // R15
        end

        // ----------------------------------------
        // sample clock and result registers
        // ----------------------------------------
        nxt_ff.tick = 1'b0;
        if (cur_ff.smp_cnt == SMP_LAST) begin // R13
            nxt_ff.smp_cnt = '0;
            nxt_ff.tick    = 1'b1;
        end else begin
            nxt_ff.smp_cnt = cur_ff.smp_cnt + 1'b1;
        end

        // level check covers the rising edge too, even in the tick cycle
        if (load_ok) begin // R8 R9 R10
            nxt_ff.res.x = st_apply(accel_i.x, self_test_en_i, self_test_polarity_bit_i); // R11 R12
            nxt_ff.res.y = st_apply(accel_i.y, self_test_en_i, self_test_polarity_bit_i); // R11 R12
        end

        // ----------------------------------------
        // read word
        // ----------------------------------------
        stat_word = status_word(cur_ff.rst_flag, cur_ff.ready, capture_hold_input_i); // R7

        unique case (cmd_now)
            CMD_READ_X:     rd_word = sext_axis(cur_ff.res.x); // R12
            CMD_READ_Y:     rd_word = sext_axis(cur_ff.res.y); // R12
            CMD_READ_SER:   rd_word = SERIAL_NUMBER; // R14
            CMD_READ_RANGE: rd_word = RANGE_CODE; // R14
            CMD_READ_FILT:  rd_word = FILTER_CODE; // R14
            CMD_READ_STAT:  rd_word = stat_word; // R14
            default:        rd_word = WORD_ZERO;
        endcase

        // ----------------------------------------
        // phase machine
        // ----------------------------------------
        unique case (cur_ff.phase)
            PH_HIZ: begin
                nxt_ff.oe = 1'b0; // R5
                if (cur_ff.ph_cnt == HIZ_LAST) begin
                    nxt_ff.phase  = PH_STAB;
                    nxt_ff.ph_cnt = '0;
                    nxt_ff.oe     = 1'b1; // R6
                    nxt_ff.tx_sr  = WORD_IDLE; // R6
                end else begin
                    nxt_ff.ph_cnt = ph_step(cur_ff.ph_cnt);
                end
            end
            PH_STAB: begin
                if (cur_ff.ph_cnt == STAB_LAST) begin // R6
                    nxt_ff.phase  = PH_RUN;
                    nxt_ff.ph_cnt = '0;
                    nxt_ff.ready  = 1'b1;
                    // the enable follows select from here on
                    nxt_ff.oe     = !select_reset_n_i;
                end else begin
                    nxt_ff.ph_cnt = ph_step(cur_ff.ph_cnt);
                end
            end
            PH_RUN: begin
                nxt_ff.oe = !select_reset_n_i; // R2
                if (select_reset_n_i) begin
                    // a frame cut short by select leaves no half word behind
                    nxt_ff.bit_cnt = 5'h00;
                    nxt_ff.tx_sr   = WORD_IDLE;
                // clocks past the last bit of a frame are ignored
                end else if (sclk_rise && cur_ff.bit_cnt != FRAME_BITS) begin // R1
                    nxt_ff.bit_cnt = cur_ff.bit_cnt + 1'b1;
                    if (cur_ff.bit_cnt < CMD_BITS) begin
                        nxt_ff.cmd_sr = cmd_now; // R1
                    end
                    if (cur_ff.bit_cnt == CMD_BITS - 5'h01) begin
                        nxt_ff.tx_sr = rd_word;
                        // the loaded word already holds the flag, so nothing is lost
                        if (cmd_now == CMD_READ_STAT) begin
                            nxt_ff.rst_flag = 1'b0; // R7
                        end
                    end
                // shift on the falling clock so the bit is settled at the next rise
                end else if (sclk_fall && cur_ff.bit_cnt > CMD_BITS) begin
                    nxt_ff.tx_sr = {cur_ff.tx_sr[WORD_W-2:0], 1'b1};
                end
            end
            default: begin
                nxt_ff = RST_STATE;
            end
        endcase

        // the pin reset restarts the whole block, including the flag
        if (hw_reset) begin // R3 R5
            nxt_ff           = RST_STATE;
            nxt_ff.sclk_prev = sclk_i;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_ff <= RST_STATE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // dout idles high, so a selected but idle port reads all ones
    assign dout_o        = cur_ff.tx_sr[WORD_W-1];
    assign dout_oe_o     = cur_ff.oe; // R2 R5
    assign ready_o       = cur_ff.ready; // R16
    assign sample_tick_o = cur_ff.tick;

endmodule

//--- accel_port_pkg.sv
package accel_port_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int unsigned MCLK_MHZ       = 250;
    localparam int unsigned RST_HOLD_US    = 512;
    localparam int unsigned HIZ_US         = 800;
    localparam int unsigned STAB_MS        = 3;
    localparam int unsigned SAMPLE_US      = 16;
    localparam int unsigned RST_HOLD_CYC   = RST_HOLD_US * MCLK_MHZ;
    localparam int unsigned HIZ_CYC        = HIZ_US * MCLK_MHZ;
    localparam int unsigned STAB_CYC       = STAB_MS * 1000 * MCLK_MHZ;
    localparam int unsigned SAMPLE_CYC     = SAMPLE_US * MCLK_MHZ;

    localparam int unsigned RD_CNT_W       = 20;
    localparam int unsigned PH_CNT_W       = 20;
    localparam int unsigned SMP_CNT_W      = 12;

    // ----------------------------------------
    // serial frame
    // ----------------------------------------
    localparam int unsigned AXIS_W         = 10;
    localparam int unsigned WORD_W         = 16;
    localparam int unsigned CMD_W          = 8;
    localparam logic [4:0]  CMD_BITS       = 5'h08;
    localparam logic [4:0]  FRAME_BITS     = 5'h18;
    localparam logic [7:0]  CMD_READ_X     = 8'h01;
    localparam logic [7:0]  CMD_READ_Y     = 8'h02;
    localparam logic [7:0]  CMD_READ_SER   = 8'h03;
    localparam logic [7:0]  CMD_READ_RANGE = 8'h04;
    localparam logic [7:0]  CMD_READ_FILT  = 8'h05;
    localparam logic [7:0]  CMD_READ_STAT  = 8'h06;
    localparam logic [15:0] WORD_IDLE      = 16'hffff;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    // status word bit positions
    localparam int unsigned STAT_RST_BIT   = 0;
    localparam int unsigned STAT_RDY_BIT   = 1;
    localparam int unsigned STAT_HOLD_BIT  = 2;

    // self-test deflection, in counts
    localparam logic signed [9:0] ST_OFFSET = 10'sh040;
    localparam logic signed [9:0] AXIS_MAX  = 10'sh1ff;
    localparam logic signed [9:0] AXIS_MIN  = -10'sh200;

    typedef enum logic [2:0] {
        PH_HIZ  = 3'b001,
        PH_STAB = 3'b010,
        PH_RUN  = 3'b100
    } phase_t;

    typedef struct packed {
        logic signed [AXIS_W-1:0] x;
        logic signed [AXIS_W-1:0] y;
    } axis_t;

endpackage

//--- accel_port_chk.sv
module accel_port_chk
    import accel_port_pkg::*;
#(
    parameter int unsigned RST_HOLD_CYCLES = 20,
    parameter int unsigned HIZ_CYCLES      = 30,
    parameter int unsigned STAB_CYCLES     = 40
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic select_reset_n_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic ready_o,
    input wire logic sample_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ----------------------------------------
    // phase and gap counters
    // ----------------------------------------
    logic [19:0] hold_ff, hiz_ff, stab_ff, gap_ff;
    logic        seen_ff;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_ff <= 20'h0_0000;
            hiz_ff  <= 20'h0_0000;
            stab_ff <= 20'h0_0000;
            gap_ff  <= 20'h0_0000;
            seen_ff <= 1'b0;
        end else begin
            hold_ff <= (!select_reset_n_i && sclk_i) ? hold_ff + 20'h0_0001 : 20'h0_0000;
            hiz_ff  <= (!ready_o && !dout_oe_o) ? hiz_ff + 20'h0_0001 : 20'h0_0000;
            stab_ff <= (!ready_o && dout_oe_o) ? stab_ff + 20'h0_0001 : 20'h0_0000;
            gap_ff  <= sample_tick_o ? 20'h0_0000 : gap_ff + 20'h0_0001;
            // arm only on a tick seen while running, so a pin reset cannot fake a gap
            seen_ff <= sample_tick_o ? ready_o : (ready_o && seen_ff);
        end
    end
    sequence s_quiet;
        !dout_oe_o && !ready_o;
    endsequence
    a_oe_follows_select: assert property (ready_o && $past(ready_o) |-> dout_oe_o == !$past(select_reset_n_i))
        else $error("output enable does not follow select");
    a_quiet_after_rst: assert property ($rose(reset_n_i) |-> s_quiet ##1 s_quiet)
        else $error("output driven right after reset");
    a_hiz_length: assert property ($rose(dout_oe_o) && !ready_o |-> hiz_ff inside {[HIZ_CYCLES-1:HIZ_CYCLES+1]})
        else $error("high impedance interval has wrong length");
    a_stab_drives_high: assert property (!ready_o && dout_oe_o |-> dout_o)
        else $error("output not high during stabilization");
    a_stab_length: assert property ($rose(ready_o) |-> stab_ff inside {[STAB_CYCLES-1:STAB_CYCLES+1]})
        else $error("stabilization delay has wrong length");
    a_pin_reset: assert property (hold_ff >= RST_HOLD_CYCLES + 2 |-> !ready_o && !dout_oe_o)
        else $error("pin reset not taken");
    a_no_early_reset: assert property ($fell(ready_o) |-> $past(hold_ff) >= RST_HOLD_CYCLES - 2)
        else $error("internal reset without full hold");
    a_tick_period: assert property (sample_tick_o && seen_ff |-> gap_ff == SAMPLE_CYC - 1)
        else $error("sample period wrong");
    a_tick_pulse: assert property (sample_tick_o |=> !sample_tick_o)
        else $error("sample tick longer than one cycle");
endmodule

//--- accel_host_model.sv
module accel_host_model (
    input  wire logic mclk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output logic      sclk_o,
    output logic      select_n_o,
    output logic      din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff = 1'b0;
    logic miso;
    // a released line shows the inverse, so a read of a floating pin never matches
    always @(posedge mclk_i) if (dout_oe_i) last_ff <= dout_i;
    assign miso = dout_oe_i ? dout_i : ~last_ff;
    initial begin
        sclk_o     = 1'b0;
        select_n_o = 1'b1;
        din_o      = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic frame(input logic [7:0] cmd, output logic [15:0] word);
        logic [23:0] tx;
        tx = {cmd, 16'h0000};
        word = 16'h0000;
        select_n_o = 1'b0;
        step(3);
        for (int i = 23; i >= 0; i--) begin
            din_o = tx[i];
            step(3);
            sclk_o = 1'b1;
            if (i < 16) word = {word[14:0], miso};
            step(3);
            sclk_o = 1'b0;
        end
        select_n_o = 1'b1;
        step(3);
    endtask
    task automatic pin_reset(input int n);
        select_n_o = 1'b0;
        sclk_o = 1'b1;
        step(n);
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        step(1);
    endtask
endmodule

//--- dual_axis_accel_serial_port_bench.sv
module dual_axis_accel_serial_port_bench;
    import accel_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned RST_N = 20;
    logic  mclk_i, reset_n_i, sclk_i, select_reset_n_i, din_i, hold, st_en, st_pol;
    logic  dout_o, dout_oe_o, ready_o, sample_tick_o;
    axis_t accel;
    int    failures, cmp_count;
    logic [23:0] rows [6] = '{24'h01_00f0, 24'h02_fffb, 24'h03_1234, 24'h04_0001,
                              24'h05_0001, 24'h07_0000};
    accel_serial_port #(.RST_HOLD_CYCLES(RST_N), .HIZ_CYCLES(30), .STAB_CYCLES(40)) dut_u (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
        .select_reset_n_i(select_reset_n_i), .din_i(din_i), .capture_hold_input_i(hold),
        .self_test_en_i(st_en), .self_test_polarity_bit_i(st_pol), .accel_i(accel),
        .dout_o(dout_o), .dout_oe_o(dout_oe_o), .ready_o(ready_o), .sample_tick_o(sample_tick_o));
    accel_host_model host_u (.mclk_i(mclk_i), .dout_i(dout_o), .dout_oe_i(dout_oe_o),
        .sclk_o(sclk_i), .select_n_o(select_reset_n_i), .din_o(din_i));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // ----------------------------------------
    // checking and waiting
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic read(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] w;
        host_u.frame(cmd, w);
        check(w, exp);
    endtask
    task automatic wait_ready;
        repeat (200) begin
            if (ready_o === 1'b1) break;
            host_u.step(1);
        end
        check({15'h0000, ready_o}, 16'h0001);
    endtask
    // one tick plus two cycles, the load cycle and one more, so the result registers have settled
    task automatic wait_tick;
        repeat (5000) begin
            host_u.step(1);
            if (sample_tick_o === 1'b1) break;
        end
        host_u.step(2);
    endtask
    task automatic stop_test;
        $display("comparisons=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge mclk_i);
        failures++;
        stop_test;
    end
    initial begin
        failures = 0;
        cmp_count = 0;
        reset_n_i = 1'b0;
        {hold, st_en, st_pol} = 3'h0;
        accel = {10'h0f0, 10'h3fb};
        repeat (2) @(posedge mclk_i);
        #1 reset_n_i = 1'b1;
        wait_ready;
        wait_tick;
        foreach (rows[i]) read(rows[i][23:16], rows[i][15:0]);
        hold = 1'b1;
        accel = {10'h010, 10'h3fb};
        wait_tick;
        read(8'h01, 16'h00f0);
        hold = 1'b0;
        wait_tick;
        read(8'h01, 16'h0010);
        st_en = 1'b1;
        accel = {10'h1f0, 10'h3fb};
        wait_tick;
        read(8'h01, 16'h01ff);
        read(8'h02, 16'h003b);
        st_pol = 1'b1;
        wait_tick;
        read(8'h01, 16'h01b0);
        read(8'h02, 16'hffbb);
        host_u.pin_reset(RST_N - 4);
        host_u.pin_reset(RST_N - 4);
        check({15'h0000, ready_o}, 16'h0001);
        host_u.pin_reset(RST_N + 5);
        check({15'h0000, ready_o}, 16'h0000);
        wait_ready;
        read(8'h06, 16'h0003);
        read(8'h06, 16'h0002);
        stop_test;
    end
endmodule
bind accel_serial_port accel_port_chk #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES),
    .HIZ_CYCLES(HIZ_CYCLES), .STAB_CYCLES(STAB_CYCLES)) chk_u (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
    .select_reset_n_i(select_reset_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .ready_o(ready_o), .sample_tick_o(sample_tick_o));
